// File: testbench/irq_map_asserts.sv
/*
 checker for the irq map ports.
 assumes bind to irq_vector_priority_map.
*/
`timescale 1ns/1ps
module irq_map_asserts (
	input wire clock,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire irqOut,
	input wire winValid_r,
	input wire [5:0] winVector_r,
	input wire [6:0] winIrq_r,
	input wire [2:0] winPriority_r
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_ready_comb: assert property (pready == (psel && penable))
		else $error("pready wrong");
	chk_line_valid: assert property (irqOut == winValid_r)
		else $error("irq line differs from valid");
	chk_idle_zero: assert property (!winValid_r |-> winVector_r == 0 && winIrq_r == 0)
		else $error("idle winner not zero");
	chk_prio_live: assert property (winValid_r |-> winPriority_r != 0)
		else $error("zero priority won");
	chk_port_vec: assert property (winValid_r && winIrq_r <= 50 |-> winVector_r == 33)
		else $error("port change vector");
	chk_spi2_vec: assert property (winIrq_r inside {[53:55]} |-> winVector_r == 35)
		else $error("serial 2 vector");
	chk_uart3_vec: assert property (winIrq_r inside {[62:64]} |-> winVector_r == 38)
		else $error("uart3 vector");
	chk_own_vec: assert property (winIrq_r inside {[72:76]} |-> winVector_r == winIrq_r - 30)
		else $error("own vector");
	chk_spi4_vec: assert property (winIrq_r inside {[81:83]} |-> winVector_r == 49)
		else $error("serial 4 vector");
endmodule // irq_map_asserts
bind irq_vector_priority_map irq_map_asserts i_irq_map_asserts (.clock(clock),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .irqOut(irqOut),
	.winValid_r(winValid_r), .winVector_r(winVector_r), .winIrq_r(winIrq_r),
	.winPriority_r(winPriority_r));

// File: testbench/periph_model.sv
/*
 peripheral request model: puts the bench raise mask on the request lines.
 assumes requests synchronous to clock.
*/
`timescale 1ns/1ps
module periph_model (
	input wire clock,
	input wire [39:0] raise,
	output reg [39:0] irqRequest
);
	initial irqRequest = 40'h0000000000;
	always @(posedge clock) begin
		irqRequest <= raise;
	end
endmodule // periph_model

// File: testbench/tb_irq_vector_priority_map.sv
/*
 self-checking bench for the irq map over apb.
 assumes periph_model drives the request lines.
*/
`timescale 1ns/1ps
module tb_irq_vector_priority_map;
	reg clock = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] paddr = 8'h00;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [31:0] pwdata = 32'h00000000;
	reg [39:0] raise = 40'h0000000000;
	wire [31:0] prdata;
	wire pready, pslverr, irqOut, winValid_r;
	wire [39:0] irqRequest;
	wire [5:0] winVector_r;
	wire [6:0] winIrq_r;
	wire [2:0] winPriority_r;
	wire [1:0] winSubpriority_r;
	integer err_count = 0;
	integer num_checks = 0;
	integer i;
	reg [31:0] rd;
	reg bad;
	always #10 clock = ~clock;
	periph_model i_periph_model (.clock(clock), .raise(raise), .irqRequest(irqRequest));
	irq_vector_priority_map i_irq_vector_priority_map (.clock(clock), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irqRequest(irqRequest),
		.irqOut(irqOut), .winValid_r(winValid_r), .winVector_r(winVector_r),
		.winIrq_r(winIrq_r), .winPriority_r(winPriority_r),
		.winSubpriority_r(winSubpriority_r));
	task close_out;
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		bad = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task fire(input [39:0] m);
		@(posedge clock); raise <= m;
		@(posedge clock); raise <= 40'h0000000000;
		repeat (4) @(posedge clock);
	endtask
	task settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask
	function [5:0] vec(input integer q);
		if (q <= 50) vec = 33; else if (q <= 52) vec = 34; else if (q <= 55) vec = 35;
		else if (q <= 58) vec = 36; else if (q <= 61) vec = 37; else if (q <= 64) vec = 38;
		else if (q <= 67) vec = 39; else if (q <= 70) vec = 40; else if (q <= 71) vec = 41;
		else if (q <= 76) vec = q - 30; else if (q <= 77) vec = 47; else if (q <= 80) vec = 48;
		else vec = 49;
	endfunction
	task t_regs;
		apb(0, 8'h10, 0); chk(rd, 0);
		apb(1, 8'h14, 32'hFFFFFFFF); apb(0, 8'h14, 0); chk(rd, 32'h1F1F1F1F);
		apb(0, 8'h2C, 0); chk(bad, 1); chk(rd, 0);
	endtask
	task t_map;
		apb(1, 8'h08, 32'hFFFFF000); apb(1, 8'h0C, 32'h000FFFFF);
		for (i = 0; i < 5; i = i + 1) apb(1, 8'(8'h10 + 4 * i), 32'h04040404);
		for (i = 44; i < 84; i = i + 1) begin
			fire(40'd1 << (i - 44));
			apb(0, 8'h28, 0); chk(rd, 32'h80010000 | (i << 8) | vec(i));
			chk(irqOut, 1);
			apb(0, (i < 64) ? 8'h00 : 8'h04, 0);
			chk(rd, 32'd1 << ((i < 64) ? i - 32 : i - 64));
			apb(1, (i < 64) ? 8'h00 : 8'h04, 32'd1 << ((i < 64) ? i - 32 : i - 64));
		end
	endtask
	task t_tie;
		fire(40'h8000000001); settle; chk(winIrq_r, 44);
		apb(1, 8'h20, 32'h00000504); settle; chk(winIrq_r, 83); chk(winSubpriority_r, 1);
		apb(1, 8'h20, 32'h00000004); apb(1, 8'h00, 32'h1000); settle; chk(irqOut, 0);
		apb(1, 8'h04, 32'h80000);
	endtask
	task t_mask;
		apb(1, 8'h0C, 0); fire(40'd1 << 20); settle; chk(irqOut, 0);
		apb(0, 8'h04, 0); chk(rd, 1);
		apb(1, 8'h0C, 32'h000FFFFF); settle; chk(irqOut, 1);
		apb(1, 8'h04, 1); settle; chk(irqOut, 0);
	endtask
	task t_small;
		apb(1, 8'h24, 1); fire(40'd1 << 26); apb(0, 8'h04, 0); chk(rd, 0);
		apb(0, 8'h0C, 0); chk(rd, 32'h0001FF0F); chk(irqOut, 0);
		apb(1, 8'h24, 0);
	endtask
	task t_edge;
		@(posedge clock); raise <= (40'd1 << 28) | (40'd1 << 12);
		apb(1, 8'h04, 32'h100); apb(1, 8'h00, 32'h01000000);
		apb(0, 8'h04, 0); chk(rd, 0);
		apb(0, 8'h00, 0); chk(rd, 32'h01000000);
		@(posedge clock); raise <= 40'h0000000000;
		apb(1, 8'h00, 32'h01000000);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs; t_map; t_tie; t_mask; t_small; t_edge;
		close_out;
	end
	initial begin
		#400000;
		err_count = err_count + 1;
		close_out;
	end
endmodule // tb_irq_vector_priority_map

// File: verilog/irq_flag_cell.v
/*
 one sticky interrupt flag with set-over-clear.
 assumes requests synchronous to clock; persistent sources are levels,
 non-persistent sources set on a rising edge only.
*/
`timescale 1ns/1ps
module irq_flag_cell #(
	parameter PERSIST = 1
) (
	input wire clock,
	input wire sys_rst,
	input wire request,
	input wire clearPulse,
	input wire implemented,
	output reg flag_r
);
	reg reqPrev_r;
	wire setEvent;
	wire flag_nxt;

	// level keeps setting while held, edge sets once
	assign setEvent = implemented & (PERSIST ? request : (request & ~reqPrev_r));
	// set wins over a clear in the same cycle
	assign flag_nxt = setEvent | (flag_r & ~clearPulse & implemented);

	always @(posedge clock) begin
		if (sys_rst) begin
			flag_r <= 1'b0;
			reqPrev_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			reqPrev_r <= request;
		end
	end
endmodule // irq_flag_cell

// File: verilog/irq_map_consts.vh
/*
 constants for the irq vector and priority map: register offsets, field positions,
 irq numbering, vector numbers and reset values. assumes inclusion by bare name.
*/
`ifndef IRQ_MAP_CONSTS_VH
`define IRQ_MAP_CONSTS_VH

// register byte offsets
`define OFS_FLAG_WORD1 8'h00
`define OFS_FLAG_WORD2 8'h04
`define OFS_ENABLE_WORD1 8'h08
`define OFS_ENABLE_WORD2 8'h0C
`define OFS_PRIO_CTRL_8 8'h10
`define OFS_PRIO_CTRL_12 8'h20
`define OFS_CONFIG 8'h24
`define OFS_WINNER 8'h28

// source numbering
`define NUM_SRC 40
`define IRQ_BASE 7'd44
`define WORD1_SHIFT 12
`define WORD1_SRC 20
`define NUM_SLOT 20
`define VEC_BASE 6'd32

// vector numbers
`define VEC_PORT_CHANGE 6'd33
`define VEC_PARALLEL 6'd34
`define VEC_SERIAL2 6'd35
`define VEC_UART2 6'd36
`define VEC_TWOWIRE2 6'd37
`define VEC_UART3 6'd38
`define VEC_UART4 6'd39
`define VEC_UART5 6'd40
`define VEC_CHARGE 6'd41
`define VEC_DMA_CHANNEL_ZERO 6'd42
`define VEC_COMPARATOR3 6'd46
`define VEC_CAN_PORT_ONE 6'd47
`define VEC_SERIAL3 6'd48
`define VEC_SERIAL4 6'd49

// priority slot layout
`define SLOT_PRIO_MSB 4
`define SLOT_PRIO_LSB 2
`define SLOT_SUB_MSB 1
`define SLOT_SUB_LSB 0
`define SLOT_MASK 8'h1F
`define SLOT_RESET 5'h00

// winner and config register fields
`define WIN_VALID_BIT 31
`define CFG_SMALL_BIT 0
`define CFG_RESET 1'b0

`endif

// File: verilog/irq_vector_priority_map.v
/*
 interrupt map for irq 44 to 83: sticky flags, enables, priority control
 registers 8 to 12, package variant masking and winner selection, over apb.
 assumes peripheral requests synchronous to clock and a single apb master.
*/
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "irq_map_consts.vh"
module irq_vector_priority_map (
	input wire clock,
	input wire sys_rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [39:0] irqRequest,
	output reg irqOut,
	output reg winValid_r,
	output reg [5:0] winVector_r,
	output reg [6:0] winIrq_r,
	output reg [2:0] winPriority_r,
	output reg [1:0] winSubpriority_r
);
	// source index to vector number
	function [5:0] vec_of;
		input integer idx;
		begin
			if (idx <= 6)
				vec_of = `VEC_PORT_CHANGE;
			else if (idx <= 8)
				vec_of = `VEC_PARALLEL;
			else if (idx <= 11)
				vec_of = `VEC_SERIAL2;
			else if (idx <= 14)
				vec_of = `VEC_UART2;
			else if (idx <= 17)
				vec_of = `VEC_TWOWIRE2;
			else if (idx <= 20)
				vec_of = `VEC_UART3;
			else if (idx <= 23)
				vec_of = `VEC_UART4;
			else if (idx <= 26)
				vec_of = `VEC_UART5;
			else if (idx == 27)
				vec_of = `VEC_CHARGE;
			else if (idx <= 31)
				vec_of = `VEC_DMA_CHANNEL_ZERO + idx[5:0] - 6'd28;
			else if (idx == 32)
				vec_of = `VEC_COMPARATOR3;
			else if (idx == 33)
				vec_of = `VEC_CAN_PORT_ONE;
			else if (idx <= 36)
				vec_of = `VEC_SERIAL3;
			else
				vec_of = `VEC_SERIAL4;
		end
	endfunction

	// sources missing on the small package
	function small_gone;
		input integer idx;
		begin
			small_gone = (idx >= 24 && idx <= 27) || (idx >= 37);
		end
	endfunction

	// dma and comparator 3 are edge sourced
	function persist_of;
		input integer idx;
		begin
			persist_of = !(idx >= 28 && idx <= 32);
		end
	endfunction

	// apb phases and decode
	wire setupPhase;
	wire accessPhase;
	wire writeStrobe;
	reg addrHit;
	reg [31:0] readWord;

	// state
	wire [39:0] flag;
	reg [39:0] enable_r;
	reg [4:0] prioSlot_r [0:19];
	reg smallPackage_r;

	// derived per source
	wire [39:0] implemented;
	wire [39:0] pending;
	wire [39:0] clearPulse;
	wire [199:0] keyFlat;
	wire [39:0] word1Clear;
	wire [39:0] word2Clear;

	// winner
	wire [5:0] selIndex;
	wire [4:0] selKey;
	wire selValid;

	integer s;
	integer r;

	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	// zero wait state: answer in the first access cycle
	assign pready = accessPhase;
	assign pslverr = accessPhase & ~addrHit;
	assign writeStrobe = accessPhase & pwrite & addrHit;

	// flag words: irq 44-63 at word 1 bits 12-31, irq 64-83 at word 2 bits 0-19
	assign word1Clear = {20'h00000, pwdata[31:`WORD1_SHIFT]};
	assign word2Clear = {pwdata[19:0], 20'h00000};

	assign clearPulse = (writeStrobe && paddr == `OFS_FLAG_WORD1) ? word1Clear :
		(writeStrobe && paddr == `OFS_FLAG_WORD2) ? word2Clear : 40'h0000000000;

	genvar g;
	generate
		for (g = 0; g < `NUM_SRC; g = g + 1) begin : srcGen
			localparam [5:0] VEC = vec_of(g);
			localparam integer SLOT = VEC - `VEC_BASE;
			localparam GONE = small_gone(g);
			wire [4:0] slotVal;

			assign implemented[g] = ~(GONE & smallPackage_r);
			assign slotVal = prioSlot_r[SLOT];
			assign keyFlat[g*5 +: 5] = slotVal;
			// zero priority never competes
			assign pending[g] = flag[g] & enable_r[g] & implemented[g] &
				(slotVal[`SLOT_PRIO_MSB:`SLOT_PRIO_LSB] != 3'h0);

			irq_flag_cell #(
				.PERSIST(persist_of(g))
			) flagCell (
				.clock(clock),
				.sys_rst(sys_rst),
				.request(irqRequest[g]),
				.clearPulse(clearPulse[g]),
				.implemented(implemented[g]),
				.flag_r(flag[g])
			);
		end
	endgenerate

	irq_winner_select winnerSel (
		.pending(pending),
		.keyFlat(keyFlat),
		.winIndex(selIndex),
		.winKey(selKey),
		.winValid(selValid)
	);

	// address decode and read mux
	always @* begin
		addrHit = 1'b1;
		readWord = 32'h00000000;
		if (paddr == `OFS_FLAG_WORD1) begin
			readWord = {flag[19:0], 12'h000};
		end else if (paddr == `OFS_FLAG_WORD2) begin
			readWord = {12'h000, flag[39:20]};
		end else if (paddr == `OFS_ENABLE_WORD1) begin
			readWord = {enable_r[19:0] & implemented[19:0], 12'h000};
		end else if (paddr == `OFS_ENABLE_WORD2) begin
			readWord = {12'h000, enable_r[39:20] & implemented[39:20]};
		end else if (paddr >= `OFS_PRIO_CTRL_8 && paddr <= `OFS_PRIO_CTRL_12 &&
			paddr[1:0] == 2'b00) begin
			// top three bits of each byte stay zero
			for (r = 0; r < 4; r = r + 1) begin
				readWord[r*8 +: 8] = {3'b000,
					prioSlot_r[{paddr[4:2] - 3'h4, 2'b00} + r[4:0]]};
			end
		end else if (paddr == `OFS_CONFIG) begin
			readWord[`CFG_SMALL_BIT] = smallPackage_r;
		end else if (paddr == `OFS_WINNER) begin
			readWord[`WIN_VALID_BIT] = winValid_r;
			readWord[21:20] = winSubpriority_r;
			readWord[18:16] = winPriority_r;
			readWord[14:8] = winIrq_r;
			readWord[5:0] = winVector_r;
		end else begin
			addrHit = 1'b0;
		end
	end

	// read data captured in the setup cycle
	always @(posedge clock) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			prdata <= readWord;
		end
	end

	// enable words
	always @(posedge clock) begin
		if (sys_rst) begin
			enable_r <= 40'h0000000000;
		end else if (writeStrobe && paddr == `OFS_ENABLE_WORD1) begin
			enable_r[19:0] <= pwdata[31:`WORD1_SHIFT];
		end else if (writeStrobe && paddr == `OFS_ENABLE_WORD2) begin
			enable_r[39:20] <= pwdata[19:0];
		end
	end

	// priority control slots: five bits kept per byte
	always @(posedge clock) begin
		if (sys_rst) begin
			for (s = 0; s < `NUM_SLOT; s = s + 1) begin
				prioSlot_r[s] <= `SLOT_RESET;
			end
		end else if (writeStrobe && paddr >= `OFS_PRIO_CTRL_8 &&
			paddr <= `OFS_PRIO_CTRL_12) begin
			for (s = 0; s < 4; s = s + 1) begin
				prioSlot_r[{paddr[4:2] - 3'h4, 2'b00} + s[4:0]] <=
					pwdata[s*8 +: 5];
			end
		end
	end

	// package variant
	always @(posedge clock) begin
		if (sys_rst) begin
			smallPackage_r <= `CFG_RESET;
		end else if (writeStrobe && paddr == `OFS_CONFIG) begin
			smallPackage_r <= pwdata[`CFG_SMALL_BIT];
		end
	end

	// winning vector and interrupt line
	always @(posedge clock) begin
		if (sys_rst) begin
			irqOut <= 1'b0;
			winValid_r <= 1'b0;
			winVector_r <= 6'h00;
			winIrq_r <= 7'h00;
			winPriority_r <= 3'h0;
			winSubpriority_r <= 2'h0;
		end else begin
			irqOut <= selValid;
			winValid_r <= selValid;
			if (selValid) begin
				winVector_r <= vec_of_index(selIndex);
				winIrq_r <= `IRQ_BASE + {1'b0, selIndex};
				winPriority_r <= selKey[`SLOT_PRIO_MSB:`SLOT_PRIO_LSB];
				winSubpriority_r <= selKey[`SLOT_SUB_MSB:`SLOT_SUB_LSB];
			end else begin
				winVector_r <= 6'h00;
				winIrq_r <= 7'h00;
				winPriority_r <= 3'h0;
				winSubpriority_r <= 2'h0;
			end
		end
	end

	// runtime wrapper of the vector table
	function [5:0] vec_of_index;
		input [5:0] idx;
		integer k;
		begin
			vec_of_index = 6'h00;
			for (k = 0; k < `NUM_SRC; k = k + 1) begin
				if (idx == k[5:0])
					vec_of_index = vec_of(k);
			end
		end
	endfunction
endmodule // irq_vector_priority_map

// File: verilog/irq_winner_select.v
/*
 combinational winner pick among pending sources by priority, then subpriority,
 then lowest source index. assumes keys are {priority, subpriority}.
*/
`timescale 1ns/1ps
module irq_winner_select (
	input wire [39:0] pending,
	input wire [199:0] keyFlat,
	output reg [5:0] winIndex,
	output reg [4:0] winKey,
	output reg winValid
);
	integer i;
	reg [4:0] key;

	always @* begin
		key = 5'h00;
		winIndex = 6'h00;
		winKey = 5'h00;
		winValid = 1'b0;
		// strict greater keeps the lower index on a tie
		for (i = 0; i < 40; i = i + 1) begin
			key = keyFlat[i*5 +: 5];
			if (pending[i] && (!winValid || key > winKey)) begin
				winValid = 1'b1;
				winKey = key;
				winIndex = i[5:0];
			end
		end
	end
endmodule // irq_winner_select
